/* File: serial_far_end.sv */
// Far-end model: stands in for the serial partner and the shifters.
// Assumes one clock; every strobe is driven just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module serial_far_end (
    input wire logic aclk,
    output logic rx_done,
    output serial_flags_pkg::rx_frame_s rx_frame,
    output logic tx_load,
    output logic tx_last_bit,
    output logic xfer_tx_write
);
    // Idle state; frame lines carry no stale copy between frames.
    initial begin
        rx_done = 1'b0;
        rx_frame = '0;
        tx_load = 1'b0;
        tx_last_bit = 1'b0;
        xfer_tx_write = 1'b0;
    end
    // One received frame, valid only with its one-cycle strobe.
    task automatic send(input logic [7:0] d, input logic p, input logic m, input logic s);
        rx_frame <= {d, p, m, s};
        rx_done <= 1'b1;
        @(posedge aclk);
        rx_done <= 1'b0;
        rx_frame <= ~{d, p, m, s}; // Inverted so a late sample cannot pass.
        @(posedge aclk);
    endtask
    // One-cycle transmit side strobes: load, last bit, transfer controller write.
    task automatic tx_pulse(input logic l, input logic b, input logic x);
        {tx_load, tx_last_bit, xfer_tx_write} <= {l, b, x};
        @(posedge aclk);
        {tx_load, tx_last_bit, xfer_tx_write} <= 3'h0;
        @(posedge aclk);
    endtask
endmodule
`default_nettype wire

/* File: serial_flags.sv */
// Serial status flags and baud divisor of one serial channel.
// Assumes the shifters sit outside and report frames as one-cycle strobes.
// Operation
// - Stop bit zero sets stop fault
// - Only first stop bit is checked
// - Stop fault stores data, receive full stays
// - Faults clear by zero after read one
// - Receive disable keeps stop fault
// - Receive disable keeps parity fault
// - Parity mismatch sets parity fault
// - Parity fault stores data, receive full stays
// - Faults halt reception, sync transmission too
// - Done set by disable or empty end
// - Done cleared with empty flag clear
// - Done bit is read-only
// - Received multiprocessor bit copied to status
// - Receive disable keeps multiprocessor status
// - Send bit appended in multiprocessor format
// - Send bit ignored outside asynchronous multiprocessor
// - Eight-bit divisor on prescaled clock
// - Divisor always readable and writable
// - Divisor resets to all ones
// - Each channel has its own generator
// - Overrun when frame ends while full
// - Flags reset to empty and done only
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none

module serial_flags (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic standby, // Standby or module stop request.
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_done, // Receive shifter finished a frame.
    input wire serial_flags_pkg::rx_frame_s rx_frame, // Frame content with rx_done.
    input wire logic tx_load, // Shifter took the holding register.
    input wire logic tx_last_bit, // Last bit of a character going out.
    input wire logic xfer_tx_write, // Transfer controller wrote tx_hold.
    output logic rx_halt, // Reception stopped by a fault or overrun.
    output logic tx_halt, // Synchronous transmission stopped.
    output logic tx_mp_bit, // Multiprocessor bit to append.
    output logic [7:0] rx_hold, // Receive holding register.
    output logic rx_allow, // Receive enable.
    output logic tx_allow, // Transmit enable.
    output logic sample_tick, // 16x sampling tick.
    output logic bit_tick // One pulse per bit time.
);

    // ****************************************************************
    // State and its next value.
    // ****************************************************************
    serial_flags_pkg::state_s st_r; // Registered state.
    serial_flags_pkg::state_s st_nxt; // Next state.

    // Scratch signals of the combinational process.
    logic wr_fire; // A write has both halves.
    logic rd_fire; // A read address is taken.
    logic [7:0] wbyte; // Written low byte.
    logic sync_mode; // Clocked synchronous mode.
    logic par_bad; // Parity disagreement on this frame.
    logic pre_step; // Prescaler output tick.
    logic [31:0] rword; // Read word before registering.

    // ****************************************************************
    // Next-state logic.
    // ****************************************************************
    // All behaviour lives here; the flop below only registers it.
    always_comb begin
        st_nxt = st_r;
        wbyte = st_r.w_data[7:0];
        sync_mode = st_r.ctrl[serial_flags_pkg::CB_SYNC];
        par_bad = 1'b0;
        pre_step = 1'b0;
        rword = 32'h0000_0000;
        st_nxt.sample_tick = 1'b0;
        st_nxt.bit_tick = 1'b0;

        // Address and data may arrive in either order; each is held.
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.w_got = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end
        st_nxt.awready = !st_nxt.aw_got && !st_r.bvalid;
        st_nxt.wready = !st_nxt.w_got && !st_r.bvalid;
        wr_fire = st_r.aw_got && st_r.w_got && !st_r.bvalid;
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // Register writes through the low byte lane; control bit 8 through the second lane.
        if (wr_fire) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = serial_flags_pkg::RESP_OKAY;
            unique case (st_r.aw_addr)
                serial_flags_pkg::ADDR_FLAGS: begin
                    if (st_r.w_strb[0]) begin
                        // Zero clears a flag only if it was read as one.
                        for (int i = 3; i <= 7; i++) begin
                            if (!wbyte[i] && st_r.seen[i]) begin
                                st_nxt.flags[i] = 1'b0;
                            end
                        end
                        // Clearing empty also clears done.
                        if (!wbyte[serial_flags_pkg::BIT_TX_EMPTY]
                            && st_r.seen[serial_flags_pkg::BIT_TX_EMPTY]) begin
                            st_nxt.flags[serial_flags_pkg::BIT_TX_DONE] = 1'b0;
                        end
                        // Done and received bit ignore writes.
                        st_nxt.flags[serial_flags_pkg::BIT_TX_MP] =
                            wbyte[serial_flags_pkg::BIT_TX_MP];
                        st_nxt.seen = 8'h00;
                    end
                end
                serial_flags_pkg::ADDR_DIVISOR: begin
                    // Written in any operating state.
                    if (st_r.w_strb[0]) begin
                        st_nxt.divisor = wbyte;
                    end
                end
                serial_flags_pkg::ADDR_CTRL: begin
                    if (st_r.w_strb[0]) begin
                        st_nxt.ctrl[7:0] = wbyte;
                    end
                    if (st_r.w_strb[1]) begin
                        st_nxt.ctrl[serial_flags_pkg::CB_PRE_HI] = st_r.w_data[8];
                    end
                end
                default: begin
                    st_nxt.bresp = serial_flags_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Transfer controller writing tx_hold clears empty and done.
        if (xfer_tx_write) begin
            st_nxt.flags[serial_flags_pkg::BIT_TX_EMPTY] = 1'b0;
            st_nxt.flags[serial_flags_pkg::BIT_TX_DONE] = 1'b0;
        end

        // Read channel; reading a flag as one arms its clear.
        st_nxt.arready = !st_r.rvalid && !(s_axi_arvalid && st_r.arready);
        rd_fire = s_axi_arvalid && st_r.arready;
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (rd_fire) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = serial_flags_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                serial_flags_pkg::ADDR_FLAGS: begin
                    rword[7:0] = st_r.flags;
                    st_nxt.seen = st_r.seen | st_r.flags;
                end
                serial_flags_pkg::ADDR_DIVISOR: begin
                    rword[7:0] = st_r.divisor;
                end
                serial_flags_pkg::ADDR_CTRL: begin
                    rword[serial_flags_pkg::CTRL_W-1:0] = st_r.ctrl;
                end
                default: begin
                    st_nxt.rresp = serial_flags_pkg::RESP_SLVERR;
                end
            endcase
            st_nxt.rdata = rword;
        end

        // Transmit side flags; hardware set wins over software clear.
        if (tx_load) begin
            st_nxt.flags[serial_flags_pkg::BIT_TX_EMPTY] = 1'b1;
        end
        if (!st_r.ctrl[serial_flags_pkg::CB_TX_ALLOW]) begin
            // Transmitter off: empty and done are held set.
            st_nxt.flags[serial_flags_pkg::BIT_TX_EMPTY] = 1'b1;
            st_nxt.flags[serial_flags_pkg::BIT_TX_DONE] = 1'b1;
        end else if (tx_last_bit && st_r.flags[serial_flags_pkg::BIT_TX_EMPTY]) begin
            st_nxt.flags[serial_flags_pkg::BIT_TX_DONE] = 1'b1;
        end

        // Receive completion. Disabling receive touches no flag.
        if (rx_done && st_r.ctrl[serial_flags_pkg::CB_RX_ALLOW] && !st_r.halt) begin
            par_bad = st_r.ctrl[serial_flags_pkg::CB_PAR_EN] && !sync_mode
                && ((^rx_frame.data ^ rx_frame.par) != st_r.ctrl[serial_flags_pkg::CB_PAR_ODD]);
            st_nxt.par_calc = par_bad;
            if (st_r.flags[serial_flags_pkg::BIT_RX_FULL]) begin
                // Data lost, holding register keeps old character.
                st_nxt.flags[serial_flags_pkg::BIT_OVERRUN] = 1'b1;
            end else begin
                st_nxt.rx_hold = rx_frame.data;
                // Only stop1 is looked at; a second stop bit never is.
                if (!sync_mode && !rx_frame.stop1) begin
                    st_nxt.flags[serial_flags_pkg::BIT_STOP_FAULT] = 1'b1;
                end
                if (par_bad) begin
                    st_nxt.flags[serial_flags_pkg::BIT_PAR_FAULT] = 1'b1;
                end
                // Full is set only for a clean frame.
                if ((sync_mode || rx_frame.stop1) && !par_bad) begin
                    st_nxt.flags[serial_flags_pkg::BIT_RX_FULL] = 1'b1;
                end
                if (st_r.ctrl[serial_flags_pkg::CB_MP] && !sync_mode) begin
                    st_nxt.flags[serial_flags_pkg::BIT_RX_MP] = rx_frame.mp;
                end
            end
        end

        // Any fault or overrun holds off reception.
        st_nxt.halt = st_nxt.flags[serial_flags_pkg::BIT_STOP_FAULT]
            | st_nxt.flags[serial_flags_pkg::BIT_PAR_FAULT]
            | st_nxt.flags[serial_flags_pkg::BIT_OVERRUN];

        // Multiprocessor bit goes out only in async multiprocessor format.
        st_nxt.tx_mp_out = st_nxt.flags[serial_flags_pkg::BIT_TX_MP]
            && st_nxt.ctrl[serial_flags_pkg::CB_MP]
            && !st_nxt.ctrl[serial_flags_pkg::CB_SYNC]
            && st_nxt.ctrl[serial_flags_pkg::CB_TX_ALLOW];

        // Prescaler: select picks 1, 1/4, 1/16 or 1/64 of aclk.
        st_nxt.pre_cnt = st_r.pre_cnt + 6'h01;
        unique case ({st_r.ctrl[serial_flags_pkg::CB_PRE_HI],
                      st_r.ctrl[serial_flags_pkg::CB_PRE_LO]})
            2'h0: pre_step = 1'b1;
            2'h1: pre_step = (st_r.pre_cnt[1:0] == 2'h3);
            2'h2: pre_step = (st_r.pre_cnt[3:0] == 4'hf);
            2'h3: pre_step = (st_r.pre_cnt == 6'h3f);
        endcase

        // Divide by divisor plus one, this channel's own counter.
        if (pre_step) begin
            if (st_r.bdiv_cnt >= st_r.divisor) begin
                st_nxt.bdiv_cnt = 8'h00;
                st_nxt.sample_tick = 1'b1;
                st_nxt.ovs_cnt = st_r.ovs_cnt + 4'h1;
                // In async mode a bit lasts sixteen samples.
                if (sync_mode || st_r.ovs_cnt == serial_flags_pkg::OVS_LAST) begin
                    st_nxt.bit_tick = 1'b1;
                end
            end else begin
                st_nxt.bdiv_cnt = st_r.bdiv_cnt + 8'h01;
            end
        end

        // Standby or module stop acts like reset on flags and divisor.
        if (standby) begin
            st_nxt.flags = serial_flags_pkg::FLAGS_RESET;
            st_nxt.divisor = serial_flags_pkg::DIVISOR_RESET;
            st_nxt.seen = 8'h00;
            st_nxt.halt = 1'b0;
            st_nxt.tx_mp_out = 1'b0;
        end
    end

    // ****************************************************************
    // State register.
    // ****************************************************************
    // Synchronous reset loads constants only.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.flags <= serial_flags_pkg::FLAGS_RESET;
            st_r.divisor <= serial_flags_pkg::DIVISOR_RESET;
            st_r.ctrl <= serial_flags_pkg::CTRL_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // Outputs, each straight from the state register except tx_halt, which gates halt with the sync bit.
    // ****************************************************************
    assign s_axi_awready = st_r.awready;
    assign s_axi_wready = st_r.wready;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign rx_halt = st_r.halt;
    assign tx_halt = st_r.halt & st_r.ctrl[serial_flags_pkg::CB_SYNC];
    assign tx_mp_bit = st_r.tx_mp_out;
    assign rx_hold = st_r.rx_hold;
    assign rx_allow = st_r.ctrl[serial_flags_pkg::CB_RX_ALLOW];
    assign tx_allow = st_r.ctrl[serial_flags_pkg::CB_TX_ALLOW];
    assign sample_tick = st_r.sample_tick;
    assign bit_tick = st_r.bit_tick;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    // Frame taken with a zero first stop bit in async mode while the holding register is free.
    // Kept as a plain signal so that it can also be negated inside other antecedents.
    logic bad_stop;
    assign bad_stop = rx_done && rx_allow && !rx_halt && !st_r.ctrl[serial_flags_pkg::CB_SYNC]
        && !rx_frame.stop1 && !st_r.flags[serial_flags_pkg::BIT_RX_FULL] && !standby;

    sequence s_bad_stop;
        bad_stop;
    endsequence

    // Any frame that the receive side accepts at all.
    sequence s_frame_in;
        rx_done && rx_allow && !rx_halt && !standby;
    endsequence

    a_stop_fault_set: assert property (@(posedge aclk) disable iff (!aresetn)
        s_bad_stop |=> st_r.flags[serial_flags_pkg::BIT_STOP_FAULT])
        else $error("stop fault not set");
    a_full_stays_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        s_bad_stop |=> !st_r.flags[serial_flags_pkg::BIT_RX_FULL]
            && rx_hold == $past(rx_frame.data))
        else $error("faulted frame handling wrong");
    a_one_write_inert: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.flags[serial_flags_pkg::BIT_STOP_FAULT] && !standby && !bad_stop
            && !(wr_fire && st_r.aw_addr == serial_flags_pkg::ADDR_FLAGS && !wbyte[4])
            |=> st_r.flags[serial_flags_pkg::BIT_STOP_FAULT])
        else $error("stop fault cleared without zero write");
    a_halt_on_fault: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.flags[serial_flags_pkg::BIT_PAR_FAULT] |-> rx_halt)
        else $error("reception not halted on parity fault");
    a_done_tx_off: assert property (@(posedge aclk) disable iff (!aresetn)
        !tx_allow [*2] |-> st_r.flags[serial_flags_pkg::BIT_TX_DONE])
        else $error("done not set with transmitter off");
    a_mp_gated: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.ctrl[serial_flags_pkg::CB_SYNC] |-> !tx_mp_bit)
        else $error("mp bit sent in sync mode");
    a_divisor_std: assert property (@(posedge aclk) disable iff (!aresetn)
        standby |=> st_r.divisor == serial_flags_pkg::DIVISOR_RESET
            && st_r.flags == serial_flags_pkg::FLAGS_RESET)
        else $error("standby did not restore reset values");
    a_tick_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
        sample_tick && st_r.divisor == 8'h01 && st_r.ctrl[8:7] == 2'h0 && !standby
            |=> !sample_tick ##1 sample_tick)
        else $error("sample spacing wrong");

    // A frame landing on a full holding register is lost and only flags the overrun.
    a_overrun_set: assert property (@(posedge aclk) disable iff (!aresetn)
        s_frame_in ##0 st_r.flags[serial_flags_pkg::BIT_RX_FULL]
            |=> st_r.flags[serial_flags_pkg::BIT_OVERRUN] && rx_hold == $past(rx_hold))
        else $error("overrun not flagged");
    // In async multiprocessor format the received bit lands in the status copy.
    a_mp_copied: assert property (@(posedge aclk) disable iff (!aresetn)
        s_frame_in ##0 (st_r.ctrl[serial_flags_pkg::CB_MP]
            && !st_r.ctrl[serial_flags_pkg::CB_SYNC]
            && !st_r.flags[serial_flags_pkg::BIT_RX_FULL])
            |=> st_r.flags[serial_flags_pkg::BIT_RX_MP] == $past(rx_frame.mp))
        else $error("received mp bit not copied");

endmodule

`default_nettype wire

/* File: serial_flags_pkg.sv */
// Package for the serial status flags and baud divisor block.
// Assumes an AXI4-Lite master with 32-bit data; registers sit in one word each.
package serial_flags_pkg;

    // ****************************************************************
    // Register map (byte addresses).
    // ****************************************************************
    localparam logic [3:0] ADDR_FLAGS = 4'h0; // Serial flags register.
    localparam logic [3:0] ADDR_DIVISOR = 4'h4; // Baud divisor register.
    localparam logic [3:0] ADDR_CTRL = 4'h8; // Control and format register.

    // ****************************************************************
    // Flag bit positions in the serial flags register.
    // ****************************************************************
    localparam int BIT_TX_EMPTY = 7; // Transmit holding empty.
    localparam int BIT_RX_FULL = 6; // Receive holding full.
    localparam int BIT_OVERRUN = 5; // Overrun flag.
    localparam int BIT_STOP_FAULT = 4; // Stop bit fault.
    localparam int BIT_PAR_FAULT = 3; // Parity fault.
    localparam int BIT_TX_DONE = 2; // Transmit done.
    localparam int BIT_RX_MP = 1; // Received multiprocessor bit.
    localparam int BIT_TX_MP = 0; // Multiprocessor bit to send.

    // ****************************************************************
    // Control register bit positions.
    // ****************************************************************
    localparam int CB_RX_ALLOW = 0; // Receive enable.
    localparam int CB_TX_ALLOW = 1; // Transmit enable.
    localparam int CB_SYNC = 2; // Clocked synchronous mode when set.
    localparam int CB_PAR_EN = 3; // Parity enabled.
    localparam int CB_PAR_ODD = 4; // Odd parity when set.
    localparam int CB_TWO_STOP = 5; // Two stop bits.
    localparam int CB_MP = 6; // Multiprocessor format.
    localparam int CB_PRE_LO = 7; // Prescale select, low bit.
    localparam int CB_PRE_HI = 8; // Prescale select, high bit.
    localparam int CTRL_W = 9; // Control register width.

    // ****************************************************************
    // Reset values.
    // ****************************************************************
    localparam logic [7:0] FLAGS_RESET = 8'h84; // Empty and done set.
    localparam logic [7:0] DIVISOR_RESET = 8'hff; // Slowest rate.
    localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000; // All off.
    localparam logic [1:0] RESP_OKAY = 2'h0; // AXI okay.
    localparam logic [1:0] RESP_SLVERR = 2'h2; // AXI slave error.
    localparam logic [3:0] OVS_LAST = 4'hf; // Sixteen samples per bit.

    // One received frame as handed over by the receive shifter.
    typedef struct packed {
        logic [7:0] data; // Data bits.
        logic par; // Received parity bit.
        logic mp; // Received multiprocessor bit.
        logic stop1; // First stop bit.
    } rx_frame_s;

    // Whole state of the block.
    typedef struct packed {
        logic [7:0] flags; // Serial flags register.
        logic [7:0] divisor; // Baud divisor.
        logic [CTRL_W-1:0] ctrl; // Control register.
        logic [7:0] rx_hold; // Receive holding register.
        logic [7:0] seen; // Flags read as one since last write.
        logic [7:0] bdiv_cnt; // Divisor counter.
        logic [1:0] pre_cnt_lo; // Unused; the prescaler counts in pre_cnt alone.
        logic [5:0] pre_cnt; // Prescaler counter.
        logic [3:0] ovs_cnt; // Oversample counter.
        logic sample_tick; // One-cycle 16x sample tick.
        logic bit_tick; // One-cycle bit tick.
        logic aw_got; // Write address held.
        logic [3:0] aw_addr; // Held write address.
        logic w_got; // Write data held.
        logic [31:0] w_data; // Held write data.
        logic [3:0] w_strb; // Held strobes.
        logic bvalid; // Write response valid.
        logic [1:0] bresp; // Write response code.
        logic rvalid; // Read data valid.
        logic [31:0] rdata; // Read data.
        logic [1:0] rresp; // Read response code.
        logic awready; // Address ready.
        logic wready; // Data ready.
        logic arready; // Read address ready.
        logic halt; // Reception (and sync transmit) held off.
        logic tx_mp_out; // Multiprocessor bit for the shifter.
        logic par_calc; // Last parity check result.
    } state_s;

endpackage

/* File: serial_flags_test.sv */
// Testbench for the serial flags block: AXI4-Lite tasks and directed tests.
// Assumes the far-end model drives the shifter strobes.
`timescale 1ns/1ps
`default_nettype none
module serial_flags_test;
    localparam logic [3:0] FL = serial_flags_pkg::ADDR_FLAGS;
    localparam logic [3:0] DV = serial_flags_pkg::ADDR_DIVISOR;
    localparam logic [3:0] CT = serial_flags_pkg::ADDR_CTRL;
    logic aclk, aresetn, standby, awv, awr, wv, wr_rdy, bv, arv, arr, rv;
    logic [3:0] awa, ara;
    logic [31:0] wd, rdat, got;
    logic [1:0] bresp, rresp, resp;
    logic rx_done, tx_load, tx_last, xfer, rx_halt, tx_mp, stk, btk;
    logic [7:0] hold;
    serial_flags_pkg::rx_frame_s frame;
    int err_total, compares, n_smp, n_bit;
    serial_far_end far (.aclk(aclk), .rx_done(rx_done), .rx_frame(frame), .tx_load(tx_load),
        .tx_last_bit(tx_last), .xfer_tx_write(xfer));
    serial_flags dut (.aclk(aclk), .aresetn(aresetn), .standby(standby), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h3),
        .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
        .rx_done(rx_done), .rx_frame(frame), .tx_load(tx_load), .tx_last_bit(tx_last),
        .xfer_tx_write(xfer), .rx_halt(rx_halt), .tx_halt(), .tx_mp_bit(tx_mp),
        .rx_hold(hold), .rx_allow(), .tx_allow(), .sample_tick(stk), .bit_tick(btk));
    // Free-running 100 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // Write: address and data offered together, each dropped once taken.
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic aw_left, w_left;
        aw_left = 1'b1;
        w_left = 1'b1;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        while (aw_left || w_left || !bv) begin
            @(posedge aclk);
            if (awr && aw_left) awv <= 1'b0;
            if (awr) aw_left = 1'b0;
            if (wr_rdy && w_left) wv <= 1'b0;
            if (wr_rdy) w_left = 1'b0;
        end
    endtask
    // Read: address held until taken, then wait for the data beat.
    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        ara <= a;
        arv <= 1'b1;
        do @(posedge aclk); while (!arr);
        arv <= 1'b0;
        do @(posedge aclk); while (!rv);
        d = rdat;
        r = rresp;
    endtask
    // Counted comparison with a one-line report on mismatch.
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk(input logic [3:0] a, input logic [31:0] e);
        rd(a, got, resp);
        cmp(got, e);
    endtask
    // Count tick pulses over 64 cycles once the divider has settled.
    task automatic count_ticks();
        repeat (4) @(posedge aclk);
        {n_smp, n_bit} = '0;
        repeat (64) begin
            @(posedge aclk);
            n_smp += stk;
            n_bit += btk;
        end
    endtask
    // Single place where the run ends.
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Hang guard: the whole sequence needs well under 2000 cycles.
    initial begin
        #20000;
        err_total++;
        give_verdict();
    end
    // Directed sequence.
    initial begin
        {aresetn, standby, awv, wv, arv, awa, ara, wd, err_total, compares} = '0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk(FL, 32'h84);
        chk(DV, 32'hff);
        wr(DV, 32'h5a);
        chk(DV, 32'h5a);
        rd(4'hc, got, resp);
        cmp({30'h0, resp}, {30'h0, serial_flags_pkg::RESP_SLVERR});
        $display("test registers done");
        wr(CT, 32'h4b); // Receive, transmit, even parity, multiprocessor.
        far.send(8'h03, 1'b0, 1'b1, 1'b1);
        chk(FL, 32'hc6);
        wr(FL, 32'h80);
        far.send(8'h55, 1'b0, 1'b1, 1'b0);
        chk(FL, 32'h96);
        cmp({31'h0, rx_halt}, 32'h1);
        far.send(8'haa, 1'b0, 1'b1, 1'b1);
        cmp({24'h0, hold}, 32'h55);
        wr(CT, 32'h4a);
        chk(FL, 32'h96);
        wr(FL, 32'h96);
        wr(FL, 32'h86);
        chk(FL, 32'h96);
        wr(FL, 32'h86);
        chk(FL, 32'h86);
        wr(CT, 32'h4b);
        far.send(8'h01, 1'b0, 1'b1, 1'b1);
        chk(FL, 32'h8e);
        cmp({24'h0, hold}, 32'h01);
        wr(CT, 32'h4a);
        chk(FL, 32'h8e);
        wr(FL, 32'h86);
        $display("test receive flags done");
        wr(CT, 32'h4b);
        chk(FL, 32'h86);
        wr(FL, 32'h06);
        chk(FL, 32'h02);
        wr(FL, 32'h06);
        chk(FL, 32'h02);
        far.tx_pulse(1'b1, 1'b0, 1'b0);
        far.tx_pulse(1'b0, 1'b1, 1'b0);
        chk(FL, 32'h86);
        far.tx_pulse(1'b0, 1'b0, 1'b1);
        chk(FL, 32'h02);
        wr(FL, 32'h83);
        repeat (2) @(posedge aclk);
        cmp({31'h0, tx_mp}, 32'h1);
        wr(CT, 32'h4f);
        repeat (2) @(posedge aclk);
        cmp({31'h0, tx_mp}, 32'h0);
        standby <= 1'b1;
        @(posedge aclk);
        standby <= 1'b0;
        chk(FL, 32'h84);
        chk(DV, 32'hff);
        $display("test transmit and standby done");
        far.send(8'h11, 1'b0, 1'b0, 1'b0);
        far.send(8'h22, 1'b0, 1'b0, 1'b0);
        chk(FL, 32'he4);
        cmp({24'h0, hold}, 32'h11);
        wr(CT, 32'h03);
        wr(DV, 32'h01);
        count_ticks();
        cmp(n_smp, 32'h20);
        cmp(n_bit, 32'h02);
        wr(CT, 32'h83);
        count_ticks();
        cmp(n_smp, 32'h08);
        $display("test overrun and rate done");
        give_verdict();
    end
endmodule
`default_nettype wire
